//--- hw/fid_consts.svh
`ifndef FID_CONSTS_SVH
`define FID_CONSTS_SVH
// Command codes shared by the parallel and serial paths.
`define FID_CMD_READ 8'h00
`define FID_CMD_PROG 8'h40
`define FID_CMD_PVER 8'hC0
`define FID_CMD_ERASE 8'h20
`define FID_CMD_EVER 8'hA0
`define FID_CMD_ERRCHK 8'h80
`define FID_CMD_IDENT 8'h90
// Identification addresses and the command latch value after reset.
`define FID_IDENT_ADDR_MAKER 17'h0_0000
`define FID_IDENT_ADDR_PART 17'h0_0001
`define FID_CMD_RESET_VAL 8'h00
// Error byte layout: bit 0 flags a command error.
`define FID_ERR_BIT 0
// Timing: clock rate, program time in microseconds and erase time in tenths of a millisecond.
`define FID_CLK_MHZ 25
`define FID_PROG_TIME_US 10
`define FID_ERASE_TIME_MS_X10 95
`define FID_PROG_CYCLES (`FID_PROG_TIME_US * `FID_CLK_MHZ)
`define FID_ERASE_CYCLES (`FID_ERASE_TIME_MS_X10 * `FID_CLK_MHZ * 100)
`endif

//--- hw/fid_pkg.sv
package fid_pkg;
  // Steps of the serial command engine on the core clock.
  typedef enum logic [2:0] {
    FID_S_CMD,
    FID_S_ADDR_LO,
    FID_S_ADDR_HI,
    FID_S_PDATA,
    FID_S_ERASE2,
    FID_S_OE_WAIT,
    FID_S_RD_LATCH,
    FID_S_BUSY
  } fid_state_t;
  // Where the link sequencer stands inside one command.
  typedef enum logic [1:0] {
    FID_L_IDLE,
    FID_L_IN,
    FID_L_HALT
  } fid_link_t;
endpackage : fid_pkg

//--- hw/fid_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module fid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  // Pointer arithmetic wraps on a power of two only, so other depths are refused.
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fid_fifo: DEPTH must be a power of two, at least 2.");
  end

  ////////////////////////////////////////////////////////////////////////
  // Honest flags: full stalls the writer, empty hides stale data.
  assign in_ready = (count_ff != (AW + 1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_ff[rd_ptr_ff];

  // Storage is written only, so it needs no reset.
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  // Pointers and fill level.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule : fid_fifo
`default_nettype wire

//--- hw/fid_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fid_consts.svh"
// Functional notes
// - Parallel command 90h selects identification mode.
// - Parallel command byte is latched on write strobe rising edge.
// - Ident address 0 returns maker code, address 1 returns part code.
// - Ident command and data use ordinary read strobe sequencing.
// - Reads in read/write mode behave as reads in read-only mode.
// - Serial mode accepts read, program, verify, erase, erase verify, check.
// - Serial transfers are clocked and least significant bit first.
// - One bidirectional data pin carries serial input and output.
// - Serial clock is an input, driven only by the programmer.
// - Busy output shows an internal operation in progress.
// - Every serial transfer is exactly eight bits.
// - Busy stays high through program or erase, then drops low.
// - First transfer 80h returns the 8-bit error information.
module fid_top #(
  parameter int ERASE_CYCLES = `FID_ERASE_CYCLES,
  parameter int FIFO_DEPTH = 16,
  parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'hA5 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic program_voltage_high,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic ser_oe_b,
  output logic busy,
  input wire logic we_b,
  input wire logic oe_b,
  input wire logic ce_b,
  input wire logic [16:0] ident_address,
  input wire logic [7:0] pdata_i,
  output logic [7:0] ident_data,
  output logic pdata_oe,
  output logic mem_req,
  output logic mem_wr,
  output logic mem_erase,
  output logic [16:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  localparam int PROG_CYCLES = `FID_PROG_CYCLES;
  localparam int TW = $clog2(ERASE_CYCLES + 1);

  // The busy timer is sized for the erase wait, so it must be the longer one.
  if (ERASE_CYCLES < PROG_CYCLES || FIFO_DEPTH < 2)
  begin : g_bad_params
    $error("fid_top: ERASE_CYCLES or FIFO_DEPTH out of range.");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers on the core clock.
  logic [31:0] pin_meta_ff;
  logic [31:0] pin_sync_ff;
  logic vpp_s, oe_ser_s, sda_s, sclk_s, we_s, oe_s, ce_s;
  logic [7:0] pd_s;
  logic [16:0] pa_s;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Voltage presets low: a high preset would look like a voltage rise after reset.
      pin_meta_ff <= 32'h7FFF_FFFF;
      pin_sync_ff <= 32'h7FFF_FFFF;
    end
    else
    begin
      pin_meta_ff <= {program_voltage_high, ser_oe_b, sda_i, sclk, we_b, oe_b, ce_b,
                      pdata_i, ident_address};
      pin_sync_ff <= pin_meta_ff;
    end
  end
  assign {vpp_s, oe_ser_s, sda_s, sclk_s, we_s, oe_s, ce_s, pd_s, pa_s} = pin_sync_ff;

  ////////////////////////////////////////////////////////////////////////
  // Mode selection from the programming voltage and the serial pins.
  logic vpp_d_ff, we_d_ff, ser_mode_ff, rw_mode_ff;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vpp_d_ff <= 1'b0;
      we_d_ff <= 1'b1;
      ser_mode_ff <= 1'b0;
      rw_mode_ff <= 1'b0;
    end
    else
    begin
      vpp_d_ff <= vpp_s;
      we_d_ff <= we_s;
      if (vpp_s && !vpp_d_ff)
      begin
        ser_mode_ff <= sda_s && sclk_s && oe_ser_s;
        rw_mode_ff <= !(sda_s && sclk_s && oe_ser_s);
      end
      else if (!vpp_s)
      begin
        ser_mode_ff <= 1'b0;
        rw_mode_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parallel command latch and read path.
  logic [7:0] pcmd_ff;
  logic par_rd;
  assign par_rd = !ser_mode_ff && !oe_s && !ce_s && we_s;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pcmd_ff <= `FID_CMD_RESET_VAL;
    else if (rw_mode_ff && we_s && !we_d_ff && !ce_s)
      pcmd_ff <= pd_s;
    else if (!rw_mode_ff)
      pcmd_ff <= `FID_CMD_RESET_VAL;
  end

  // One output path serves both modes, so ident timing equals read timing.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ident_data <= 8'h00;
      pdata_oe <= 1'b0;
    end
    else
    begin
      pdata_oe <= par_rd;
      if (pcmd_ff == `FID_CMD_IDENT)
      begin
        if (pa_s == `FID_IDENT_ADDR_MAKER)
          ident_data <= MAKER_CODE;
        else if (pa_s == `FID_IDENT_ADDR_PART)
          ident_data <= PART_CODE;
        else
          ident_data <= 8'h00;
      end
      else
        ident_data <= mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the programmer's serial clock.
  logic ser_rst_b;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff, rx_byte_ff, cmd_l_ff, err_snap_ff;
  logic [1:0] in_left_ff;
  logic rx_tgl_ff, out_req_ff, out_ack_ff, err_flag_ff, out_err_ff;
  fid_pkg::fid_link_t link_ff;
  logic [7:0] rx_full;
  logic [7:0] rd_byte_ff;
  logic [2:0] tx_left_ff;
  logic [6:0] tx_sh_ff;
  assign ser_rst_b = ser_mode_ff;
  assign rx_full = {sda_i, rx_sh_ff[7:1]};

  always_ff @(posedge sclk or negedge ser_rst_b)
  begin
    if (!ser_rst_b)
    begin
      bit_cnt_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_byte_ff <= 8'h00;
      rx_tgl_ff <= 1'b0;
    end
    else if (!sda_oe && link_ff != fid_pkg::FID_L_HALT)
    begin
      rx_sh_ff <= rx_full;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7 && out_req_ff == out_ack_ff)
      begin
        rx_byte_ff <= rx_full;
        rx_tgl_ff <= !rx_tgl_ff;
      end
    end
  end

  // Command sequencing on the link; an invalid code halts the link.
  always_ff @(posedge sclk or negedge ser_rst_b)
  begin
    if (!ser_rst_b)
    begin
      link_ff <= fid_pkg::FID_L_IDLE;
      cmd_l_ff <= 8'h00;
      in_left_ff <= 2'h0;
      out_req_ff <= 1'b0;
      out_err_ff <= 1'b0;
    end
    else if (!sda_oe && bit_cnt_ff == 3'h7 && out_req_ff == out_ack_ff)
    begin
      case (link_ff)
        fid_pkg::FID_L_IDLE:
        begin
          cmd_l_ff <= rx_full;
          case (rx_full)
            `FID_CMD_READ, `FID_CMD_EVER:
            begin
              link_ff <= fid_pkg::FID_L_IN;
              in_left_ff <= 2'h2;
            end
            `FID_CMD_PROG:
            begin
              link_ff <= fid_pkg::FID_L_IN;
              in_left_ff <= 2'h3;
            end
            `FID_CMD_ERASE:
            begin
              link_ff <= fid_pkg::FID_L_IN;
              in_left_ff <= 2'h1;
            end
            `FID_CMD_PVER:
            begin
              out_req_ff <= !out_req_ff;
              out_err_ff <= 1'b0;
            end
            `FID_CMD_ERRCHK:
            begin
              out_req_ff <= !out_req_ff;
              out_err_ff <= 1'b1;
            end
            default:
              link_ff <= fid_pkg::FID_L_HALT;
          endcase
        end
        fid_pkg::FID_L_IN:
        begin
          in_left_ff <= in_left_ff - 2'h1;
          if (cmd_l_ff == `FID_CMD_ERASE && rx_full != `FID_CMD_ERASE)
            link_ff <= fid_pkg::FID_L_HALT;
          else if (in_left_ff == 2'h1)
          begin
            link_ff <= fid_pkg::FID_L_IDLE;
            if (cmd_l_ff == `FID_CMD_READ || cmd_l_ff == `FID_CMD_EVER)
            begin
              out_req_ff <= !out_req_ff;
              out_err_ff <= 1'b0;
            end
          end
        end
        default:
          link_ff <= fid_pkg::FID_L_HALT;
      endcase
    end
  end

  // Error flag survives a mode exit so the next check can report it.
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_flag_ff <= 1'b0;
      err_snap_ff <= 8'h00;
    end
    else if (ser_mode_ff && !sda_oe && bit_cnt_ff == 3'h7 && link_ff != fid_pkg::FID_L_HALT)
    begin
      if (link_ff == fid_pkg::FID_L_IDLE && rx_full == `FID_CMD_ERRCHK)
      begin
        err_snap_ff <= 8'h00;
        err_snap_ff[`FID_ERR_BIT] <= err_flag_ff;
        err_flag_ff <= 1'b0;
      end
      else if ((link_ff == fid_pkg::FID_L_IDLE && !(rx_full == `FID_CMD_READ ||
               rx_full == `FID_CMD_EVER || rx_full == `FID_CMD_PROG ||
               rx_full == `FID_CMD_ERASE || rx_full == `FID_CMD_PVER)) ||
               (cmd_l_ff == `FID_CMD_ERASE && rx_full != `FID_CMD_ERASE &&
               link_ff == fid_pkg::FID_L_IN))
        err_flag_ff <= 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge ser_rst_b)
  begin
    if (!ser_rst_b)
    begin
      sda_o <= 1'b1;
      sda_oe <= 1'b0;
      tx_left_ff <= 3'h0;
      tx_sh_ff <= 7'h00;
      out_ack_ff <= 1'b0;
    end
    else if (!sda_oe && out_req_ff != out_ack_ff)
    begin
      out_ack_ff <= out_req_ff;
      sda_oe <= 1'b1;
      tx_left_ff <= 3'h7;
      sda_o <= out_err_ff ? err_snap_ff[0] : rd_byte_ff[0];
      tx_sh_ff <= out_err_ff ? err_snap_ff[7:1] : rd_byte_ff[7:1];
    end
    else if (tx_left_ff != 3'h0)
    begin
      sda_o <= tx_sh_ff[0];
      tx_sh_ff <= {1'b0, tx_sh_ff[6:1]};
      tx_left_ff <= tx_left_ff - 3'h1;
    end
    else
      sda_oe <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte crossing into the core clock and the buffer.
  logic [2:0] rx_tgl_sync_ff;
  logic push_pend_ff;
  logic [7:0] push_byte_ff;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;

  // toggle crossing, one push per byte
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_tgl_sync_ff <= 3'h0;
      push_pend_ff <= 1'b0;
      push_byte_ff <= 8'h00;
    end
    else
    begin
      rx_tgl_sync_ff <= {rx_tgl_sync_ff[1:0], rx_tgl_ff};
      if (rx_tgl_sync_ff[2] != rx_tgl_sync_ff[1] && ser_mode_ff)
      begin
        push_pend_ff <= 1'b1;
        push_byte_ff <= rx_byte_ff;
      end
      else if (fifo_in_ready)
        push_pend_ff <= 1'b0;
    end
  end

  fid_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push_pend_ff),
    .in_ready(fifo_in_ready),
    .in_data(push_byte_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Serial command engine: drains the buffer, runs the array and the timer.
  fid_pkg::fid_state_t st_ff;
  logic [7:0] scmd_ff;
  logic [TW-1:0] tmr_ff;
  logic take;
  // Busy stalls draining, so a long erase lets the buffer fill.
  assign fifo_out_ready = ser_mode_ff && (st_ff == fid_pkg::FID_S_CMD ||
    st_ff == fid_pkg::FID_S_ADDR_LO || st_ff == fid_pkg::FID_S_ADDR_HI ||
    st_ff == fid_pkg::FID_S_PDATA || st_ff == fid_pkg::FID_S_ERASE2);
  assign take = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= fid_pkg::FID_S_CMD;
      scmd_ff <= 8'h00;
      tmr_ff <= '0;
      busy <= 1'b0;
      rd_byte_ff <= 8'h00;
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_erase <= 1'b0;
      mem_addr <= 17'h0_0000;
      mem_wdata <= 8'h00;
    end
    else if (!ser_mode_ff)
    begin
      st_ff <= fid_pkg::FID_S_CMD;
      busy <= 1'b0;
      mem_wr <= 1'b0;
      mem_erase <= 1'b0;
      mem_req <= par_rd;
      mem_addr <= pa_s;
    end
    else
    begin
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_erase <= 1'b0;
      case (st_ff)
        fid_pkg::FID_S_CMD:
          if (take)
          begin
            scmd_ff <= fifo_out_data;
            // Error check is answered on the link and a bad code halts it; neither takes bytes.
            if (fifo_out_data == `FID_CMD_ERASE)
              st_ff <= fid_pkg::FID_S_ERASE2;
            else if (fifo_out_data == `FID_CMD_PVER)
              st_ff <= fid_pkg::FID_S_OE_WAIT;
            else if (fifo_out_data == `FID_CMD_READ || fifo_out_data == `FID_CMD_PROG ||
                     fifo_out_data == `FID_CMD_EVER)
              st_ff <= fid_pkg::FID_S_ADDR_LO;
          end
        fid_pkg::FID_S_ADDR_LO:
          if (take)
          begin
            mem_addr <= {mem_addr[16:8], fifo_out_data};
            st_ff <= fid_pkg::FID_S_ADDR_HI;
          end
        fid_pkg::FID_S_ADDR_HI:
          if (take)
          begin
            mem_addr <= {1'b0, fifo_out_data, mem_addr[7:0]};
            st_ff <= (scmd_ff == `FID_CMD_PROG) ? fid_pkg::FID_S_PDATA
                                                 : fid_pkg::FID_S_OE_WAIT;
          end
        fid_pkg::FID_S_PDATA:
          if (take)
          begin
            mem_wdata <= fifo_out_data;
            mem_req <= 1'b1;
            mem_wr <= 1'b1;
            busy <= 1'b1;
            tmr_ff <= TW'(PROG_CYCLES - 1);
            st_ff <= fid_pkg::FID_S_BUSY;
          end
        fid_pkg::FID_S_ERASE2:
          if (take)
          begin
            // A wrong second byte halts the link, so the array must be left alone.
            if (fifo_out_data == `FID_CMD_ERASE)
            begin
              mem_req <= 1'b1;
              mem_erase <= 1'b1;
              busy <= 1'b1;
              tmr_ff <= TW'(ERASE_CYCLES - 1);
              st_ff <= fid_pkg::FID_S_BUSY;
            end
            else
              st_ff <= fid_pkg::FID_S_CMD;
          end
        fid_pkg::FID_S_OE_WAIT:
          if (!oe_ser_s)
          begin
            mem_req <= 1'b1;
            st_ff <= fid_pkg::FID_S_RD_LATCH;
          end
        fid_pkg::FID_S_RD_LATCH:
        begin
          rd_byte_ff <= mem_rdata;
          st_ff <= fid_pkg::FID_S_CMD;
        end
        fid_pkg::FID_S_BUSY:
          if (tmr_ff == '0)
          begin
            busy <= 1'b0;
            st_ff <= fid_pkg::FID_S_CMD;
          end
          else
            tmr_ff <= tmr_ff - 1'b1;
        default:
          st_ff <= fid_pkg::FID_S_CMD;
      endcase
    end
  end
endmodule : fid_top
`default_nettype wire

//--- verif/fid_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; strobe latencies allow for the two-flop input synchronisers.
module fid_chk #(
  parameter int ERASE_CYCLES = 300
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic program_voltage_high,
  input wire logic oe_b,
  input wire logic ce_b,
  input wire logic sda_oe,
  input wire logic busy,
  input wire logic pdata_oe,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic mem_erase
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  int busy_cnt_ff;
  // Length of the current busy stretch, so an unbounded busy is caught.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      busy_cnt_ff <= 0;
    else
      busy_cnt_ff <= busy ? busy_cnt_ff + 1 : 0;
  end
  AST_RESET_QUIET: assert property ($rose(rst_b) |-> !busy && !sda_oe && !mem_req)
    else $error("outputs active at reset release");
  AST_WR_WITH_REQ: assert property (mem_wr |-> mem_req && !mem_erase)
    else $error("program pulse without request");
  AST_WR_PULSE: assert property (mem_wr |=> !mem_wr)
    else $error("program pulse longer than one cycle");
  AST_ERASE_PULSE: assert property (mem_erase |-> mem_req ##1 !mem_erase)
    else $error("erase pulse malformed");
  AST_BUSY_MIN: assert property ($rose(busy) |=> busy [*8])
    else $error("busy dropped too early");
  AST_BUSY_MAX: assert property (busy_cnt_ff <= ERASE_CYCLES + 8)
    else $error("busy never ends");
  AST_BUSY_STALL: assert property (busy && $past(busy) |-> !mem_req)
    else $error("array access during busy");
  AST_PDATA_REL: assert property (oe_b [*5] |-> !pdata_oe)
    else $error("data driven with output enable high");
  AST_PDATA_CAUSE: assert property ($rose(pdata_oe) |-> $past(!oe_b && !ce_b, 2))
    else $error("data driven without read strobes");
  AST_SER_OFF: assert property (!program_voltage_high [*4] |-> !sda_oe)
    else $error("serial pin driven without serial mode");
endmodule : fid_chk
bind fid_top fid_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.clk(clk), .rst_b(rst_b),
  .program_voltage_high(program_voltage_high), .oe_b(oe_b), .ce_b(ce_b), .sda_oe(sda_oe),
  .busy(busy), .pdata_oe(pdata_oe), .mem_req(mem_req), .mem_wr(mem_wr), .mem_erase(mem_erase));
`default_nettype wire

//--- verif/fid_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Programmer side of the link; sclk idles high and only runs inside bytes.
module fid_prog (
  input wire logic clk,
  input wire logic sda_w,
  output logic sclk,
  output logic sda_val,
  output logic sda_drv,
  output logic ser_oe_b,
  output logic vpp
);
  // Idle levels until a mode is entered.
  initial
  begin
    sclk = 1'b1;
    sda_val = 1'b1;
    sda_drv = 1'b1;
    ser_oe_b = 1'b1;
    vpp = 1'b0;
  end
  task automatic enter(input logic ser);
    sda_val = ser; // A low data pin selects read/write mode instead.
    sda_drv = 1'b1;
    repeat (4) @(posedge clk);
    vpp <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : enter
  task automatic leave();
    @(posedge clk);
    vpp <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : leave
  task automatic send(input logic [7:0] b);
    // Bytes are spaced so each one has crossed into the core clock before the next lands.
    repeat (13) @(posedge clk);
    #7;
    sda_drv = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      sclk = 1'b0;
      sda_val = b[i];
      #3 sclk = 1'b1;
      #3;
    end
  endtask : send
  task automatic recv(output logic [7:0] b);
    sda_drv = 1'b0; // Released; the pin no longer shows our last bit.
    for (int i = 0; i < 8; i++)
    begin
      sclk = 1'b0;
      #3 sclk = 1'b1;
      b[i] = sda_w;
      #3;
    end
  endtask : recv
  task automatic oe_pulse();
    @(posedge clk);
    ser_oe_b <= 1'b0;
    repeat (6) @(posedge clk);
    ser_oe_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : oe_pulse
endmodule : fid_prog
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst_b, we_b, oe_b, ce_b, sda_o, sda_oe, busy, pdata_oe, mem_req, mem_wr;
  logic mem_erase, sclk, vpp, sda_val, sda_drv, ser_oe_b, sda_w;
  logic [16:0] ident_address, mem_addr, wr_addr;
  logic [7:0] pdata_i, ident_data, mem_wdata, mem_rdata, wr_data, rb;
  int err_count, n_tests, cyc, wr_cnt, er_cnt, oe_cnt;
  // Clock at 25 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Array stand-in and pin resolution; a floating pin toggles so it never looks valid.
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C;
  assign sda_w = sda_oe ? sda_o : (sda_drv ? sda_val : clk);
  fid_top #(.ERASE_CYCLES(300)) u_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .program_voltage_high(vpp), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .ser_oe_b(ser_oe_b), .busy(busy), .we_b(we_b), .oe_b(oe_b), .ce_b(ce_b),
    .ident_address(ident_address), .pdata_i(pdata_i), .ident_data(ident_data),
    .pdata_oe(pdata_oe), .mem_req(mem_req), .mem_wr(mem_wr), .mem_erase(mem_erase),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  fid_prog u_prog (.clk(clk), .sda_w(sda_w), .sclk(sclk), .sda_val(sda_val),
    .sda_drv(sda_drv), .ser_oe_b(ser_oe_b), .vpp(vpp));
  // Watch array strobes and the serial pin; the cycle ceiling cuts a hang short.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (mem_req === 1'b1 && mem_wr === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
    if (mem_erase === 1'b1)
      er_cnt <= er_cnt + 1;
    if (sda_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
    if (cyc == 40000)
    begin
      err_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] memf(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : memf
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic p_write(input logic [7:0] d);
    @(posedge clk);
    ce_b <= 1'b0;
    we_b <= 1'b0;
    pdata_i <= d;
    repeat (4) @(posedge clk);
    we_b <= 1'b1;
    repeat (4) @(posedge clk);
    ce_b <= 1'b1;
  endtask : p_write
  task automatic p_read(input logic [16:0] a, input logic [7:0] e);
    @(posedge clk);
    ident_address <= a;
    ce_b <= 1'b0;
    oe_b <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk(pdata_oe, 1'b1);
    chk(ident_data, e);
    oe_b <= 1'b1;
    ce_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : p_read
  // Waits for busy to rise, then returns how long it stayed high.
  task automatic busy_len(output int n);
    n = 0;
    for (int i = 0; i < 40 && busy !== 1'b1; i++)
      @(posedge clk);
    while (busy === 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : busy_len
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_parallel();
    u_prog.enter(1'b0);
    p_write(8'h90);
    p_read(17'h0_0000, 8'h5A);
    p_read(17'h0_0001, 8'hA5);
    p_read(17'h0_0002, 8'h00);
    p_write(8'h00);
    p_read(17'h0_0105, memf(17'h0_0105));
    u_prog.leave();
    p_read(17'h0_0203, memf(17'h0_0203));
    $display("parallel test done");
  endtask : t_parallel
  task automatic t_serial();
    int n;
    logic [7:0] cmds [2] = '{8'h00, 8'hA0};
    u_prog.enter(1'b1);
    u_prog.send(8'h80);
    u_prog.recv(rb);
    chk(rb, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      u_prog.send(cmds[i]);
      u_prog.send(8'h34 + i[7:0]);
      u_prog.send(8'h12);
      repeat (10) @(posedge clk);
      u_prog.oe_pulse();
      u_prog.recv(rb);
      chk(rb, memf(17'h0_1234 + i[16:0]));
      chk(mem_addr, 17'h0_1234 + i[16:0]);
    end
    u_prog.send(8'h40);
    u_prog.send(8'h78);
    u_prog.send(8'h56);
    u_prog.send(8'hC3);
    busy_len(n);
    chk(n >= 250 && n <= 254, 1'b1);
    chk(wr_cnt, 1);
    chk(wr_addr, 17'h0_5678);
    chk(wr_data, 8'hC3);
    u_prog.send(8'hC0);
    repeat (10) @(posedge clk);
    u_prog.oe_pulse();
    u_prog.recv(rb);
    chk(rb, memf(17'h0_5678));
    u_prog.send(8'h20);
    u_prog.send(8'h20);
    busy_len(n);
    chk(n >= 300 && n <= 304, 1'b1);
    chk(er_cnt, 1);
    $display("serial command test done");
  endtask : t_serial
  task automatic t_error();
    int seen, e0;
    u_prog.send(8'h55);
    repeat (10) @(posedge clk);
    seen = oe_cnt;
    u_prog.send(8'h80);
    u_prog.recv(rb);
    repeat (4) @(posedge clk);
    chk(oe_cnt, seen);
    u_prog.leave();
    u_prog.enter(1'b1);
    u_prog.send(8'h80);
    u_prog.recv(rb);
    chk(rb, 8'h01);
    u_prog.send(8'h80);
    u_prog.recv(rb);
    chk(rb, 8'h00);
    e0 = er_cnt;
    u_prog.send(8'h20);
    u_prog.send(8'h21);
    repeat (20) @(posedge clk);
    chk(er_cnt, e0);
    chk(busy, 1'b0);
    u_prog.leave();
    u_prog.enter(1'b1);
    u_prog.send(8'h80);
    u_prog.recv(rb);
    chk(rb, 8'h01);
    $display("error check test done");
  endtask : t_error
  // Sixteen bytes sent during an erase fill the buffer; they drain in order after it.
  task automatic t_fifo();
    int n, w0;
    w0 = wr_cnt;
    u_prog.send(8'h20);
    u_prog.send(8'h20);
    for (int k = 0; k < 4; k++)
    begin
      u_prog.send(8'h40);
      u_prog.send(8'h60 + k[7:0]);
      u_prog.send(8'h01);
      u_prog.send(8'hE0 + k[7:0]);
    end
    chk(busy, 1'b1);
    chk(wr_cnt, w0);
    busy_len(n);
    chk(er_cnt, 2);
    for (int k = 0; k < 4; k++)
    begin
      busy_len(n);
      chk(n >= 250 && n <= 254, 1'b1);
      chk(wr_cnt, w0 + k + 1);
      chk(wr_addr, 17'h0_0160 + k[16:0]);
      chk(wr_data, 8'hE0 + k[7:0]);
    end
    $display("buffer test done");
  endtask : t_fifo
  task automatic print_verdict();
    $display("%0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Reset for three cycles, then run the scenarios.
  initial
  begin
    rst_b = 1'b0;
    we_b = 1'b1;
    oe_b = 1'b1;
    ce_b = 1'b1;
    ident_address = 17'h0_0000;
    pdata_i = 8'h00;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_parallel();
    t_serial();
    t_error();
    t_fifo();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
